//--- sptc_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef SPTC_PARAMS_SVH
`define SPTC_PARAMS_SVH
`define SPTC_OFF_RXOVR      12'h028
`define SPTC_OFF_PATGEN     12'h000
`define SPTC_OFF_MATCH      12'h02C
`define SPTC_OFF_PHASE      12'h030
`define SPTC_OFF_IRQ_STAT   12'h038
`define SPTC_OFF_IRQ_MASK   12'h03C
`define SPTC_RXOVR_RST      32'h0000_101E
`define SPTC_RXOVR_WMASK    32'h0000_7FFF
`define SPTC_OVR_EN_BIT     14
`define SPTC_LOSF_HI        13
`define SPTC_LOSF_LO        12
`define SPTC_EQ_HI          7
`define SPTC_EQ_LO          5
`define SPTC_ALIGN_BIT      3
`define SPTC_HALF_BIT       0
`define SPTC_GEN_MODE_LO    16
`define SPTC_GEN_INJ_BIT    19
`define SPTC_GEN_PAT_LO     20
`define SPTC_MAT_SYNC_BIT   3
`define SPTC_CNT_LO_MAT     16
`define SPTC_LOS_FILT_CYC   8'd128
`define SPTC_SCALE          128
`endif

//--- sptc_pkg.sv
// types for the lane pattern test block
package sptc_pkg;
  typedef enum logic [2:0] {
    GEN_OFF = 3'h0, GEN_L15 = 3'h1, GEN_L7 = 3'h2,
    GEN_FIX = 3'h3, GEN_BAL = 3'h4, GEN_SEQ = 3'h5
  } sptc_gen_mode_t;
  typedef enum logic [2:0] {
    MAT_OFF = 3'h0, MAT_L15 = 3'h1, MAT_L7 = 3'h2, MAT_REP = 3'h3, MAT_INV = 3'h4
  } sptc_mat_mode_t;
  typedef enum logic [1:0] {
    SYN_IDLE = 2'b00, SYN_SEEN = 2'b01, SYN_RUN = 2'b11
  } sptc_sync_t;
endpackage : sptc_pkg

//--- sptc_ctl.sv
// lane override, pattern generator, matcher and error counters
`timescale 1ns/1ps
`default_nettype none
`include "sptc_params.svh"
// Overview of operation
// - override enable bit 14 makes bits 0..13 replace status values; resets 0
// - loss filter mode 13:12: 00 off, 11 heavy, 01/10 reserved; reset 01
// - heavy mode: signal loss after 128 prescaler cycles with no signal
// - equalizer level 7:5, reset 000, drives boost when overridden
// - bit 3 word alignment: 0 framer off, 1 on; reset 1
// - bit 0 selects half-rate receive data path; reset 0
// - generator mode 0 off, 1 lfsr15, 2 lfsr7
// - modes 3 repeat, 4 word/inverse, 5 zeros,word,3ff,inverse; 6-7 reserved
// - user word 29:20, ten bits, cleared on reset
// - bit 19 injects exactly one error into pattern lsb
// - sync bit set then cleared seeds checker; checking starts afterwards
// - count 30:16, scale flag 31 means count times 128
// - overflow shown as scale 1 and count all ones
// - counter reads pipelined; second read clears counter
// - phase value 27:17 and fraction bit 16, read live from the inputs, not reset
// - phase register second counter: count 14:0, scale 15
module sptc_ctl #(
  parameter int W = 10
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic [11:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             IRQ,
  input  wire logic [13:0] RX_STATUS,
  input  wire logic        PRESCALE_EN,
  input  wire logic        SIGNAL_PRESENT,
  input  wire logic        RX_BIT,
  input  wire logic        RX_BIT_VALID,
  input  wire logic [10:0] PHASE_SELECTOR_VALUE,
  input  wire logic        PHASE_FRACTION_BITS,
  input  wire logic        PHASE_ERR,
  output logic      [13:0] RX_EFFECTIVE,
  output logic             SIGNAL_LOSS,
  output logic      [W-1:0] TX_WORD
);
  logic [31:0] rxovr_r, rxovr_nxt;
  logic [2:0]  gmode_r, gmode_nxt;
  logic        inj_r, inj_nxt;
  logic [W-1:0] pat_r, pat_nxt;
  logic [2:0]  mmode_r, mmode_nxt;
  logic        sync_r, sync_nxt;
  sptc_pkg::sptc_sync_t sst_r, sst_nxt;
  logic [14:0] lfsr_g_r, lfsr_g_nxt;
  logic [1:0]  seq_r, seq_nxt;
  logic [W-1:0] tx_r, tx_nxt;
  logic [14:0] lfsr_c_r, lfsr_c_nxt;
  logic [9:0]  hist_r, hist_nxt;
  logic [15:0] mcnt_r, mcnt_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;
  logic [15:0] mhold_r, mhold_nxt;
  logic [15:0] phold_r, phold_nxt;
  logic        mrd_r, mrd_nxt;
  logic        prd_r, prd_nxt;
  logic [7:0]  los_cnt_r, los_cnt_nxt;
  logic        los_r, los_nxt;
  logic [13:0] rxe_r, rxe_nxt;
  logic [2:0]  ist_r, ist_nxt;
  logic [2:0]  imsk_r, imsk_nxt;
  logic        irq_r, irq_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        merr;
  logic        perr_ev;
  logic        ovf_ev;
  logic        exp_bit;

  // saturating scaled counter: below 2^15 counts 1:1, then scale by 128
  function automatic logic [15:0] cnt_step(input logic [15:0] c, input logic [6:0] pre);
    if (c == 16'hFFFF) cnt_step = c;
    else if (!c[15] && c[14:0] == 15'h7FFF) cnt_step = {1'b1, 15'h0100};
    else if (!c[15]) cnt_step = c + 16'h0001;
    else if (pre == 7'h7F) cnt_step = c + 16'h0001;
    else cnt_step = c;
  endfunction : cnt_step

  // read strobe aimed at one offset; both counter pipelines key on it
  function automatic logic rd_hit(input logic rd, input logic [11:0] a, input logic [11:0] off);
    rd_hit = rd && (a == off);
  endfunction : rd_hit

  logic [6:0] mpre_r, mpre_nxt, ppre_r, ppre_nxt;

  always_comb begin
    exp_bit = 1'b0;
    unique case (mmode_r)
      sptc_pkg::MAT_L15: exp_bit = lfsr_c_r[14] ^ lfsr_c_r[13];
      sptc_pkg::MAT_L7:  exp_bit = lfsr_c_r[6] ^ lfsr_c_r[5];
      sptc_pkg::MAT_REP: exp_bit = hist_r[9];
      sptc_pkg::MAT_INV: exp_bit = ~hist_r[9];
      default:           exp_bit = RX_BIT;
    endcase
    merr = RX_BIT_VALID && (sst_r == sptc_pkg::SYN_RUN) && (exp_bit != RX_BIT)
           && (mmode_r != 3'h0) && (mmode_r < 3'h5);
    perr_ev = PHASE_ERR;
  end

  always_comb begin
    rxovr_nxt = rxovr_r;
    gmode_nxt = gmode_r;
    inj_nxt   = inj_r;
    pat_nxt   = pat_r;
    mmode_nxt = mmode_r;
    sync_nxt  = sync_r;
    imsk_nxt  = imsk_r;
    if (WR) begin
      unique case (ADDR)
        `SPTC_OFF_RXOVR: rxovr_nxt = WDATA & `SPTC_RXOVR_WMASK;
        `SPTC_OFF_PATGEN: begin
          gmode_nxt = WDATA[`SPTC_GEN_MODE_LO +: 3];
          inj_nxt   = WDATA[`SPTC_GEN_INJ_BIT];
          pat_nxt   = WDATA[`SPTC_GEN_PAT_LO +: W];
        end
        `SPTC_OFF_MATCH: begin
          mmode_nxt = WDATA[2:0];
          sync_nxt  = WDATA[`SPTC_MAT_SYNC_BIT];
        end
        `SPTC_OFF_IRQ_MASK: imsk_nxt = WDATA[2:0];
        default: ;
      endcase
    end
    if (inj_r && gmode_r != 3'h0) inj_nxt = 1'b0;
  end

  // checker sync: rise then fall arms checking
  always_comb begin
    sst_nxt = sst_r;
    unique case (sst_r)
      sptc_pkg::SYN_IDLE: if (sync_r) sst_nxt = sptc_pkg::SYN_SEEN;
      sptc_pkg::SYN_SEEN: if (!sync_r) sst_nxt = sptc_pkg::SYN_RUN;
      sptc_pkg::SYN_RUN:  if (sync_r || mmode_r == 3'h0) sst_nxt = sync_r ?
                            sptc_pkg::SYN_SEEN : sptc_pkg::SYN_IDLE;
      default: sst_nxt = sptc_pkg::SYN_IDLE;
    endcase
    lfsr_c_nxt = lfsr_c_r;
    hist_nxt   = hist_r;
    if (RX_BIT_VALID) begin
      hist_nxt = {hist_r[8:0], RX_BIT};
      // while seeding, the checker lfsr loads received bits
      if (sst_r != sptc_pkg::SYN_RUN) lfsr_c_nxt = {lfsr_c_r[13:0], RX_BIT};
      else lfsr_c_nxt = {lfsr_c_r[13:0], exp_bit};
    end
  end

  // generator: one word per cycle, serialised elsewhere
  always_comb begin
    logic [14:0] l;
    logic [W-1:0] w;
    l = lfsr_g_r;
    w = '0;
    seq_nxt = seq_r + 2'h1;
    for (int i = W - 1; i >= 0; i--) begin
      if (gmode_r == sptc_pkg::GEN_L15) l = {l[13:0], l[14] ^ l[13]};
      else l = {l[13:0], l[6] ^ l[5]};
      w[i] = l[0];
    end
    // word modes leave the lfsr frozen, so a later lfsr run resumes its sequence
    lfsr_g_nxt = (gmode_r == sptc_pkg::GEN_L15 || gmode_r == sptc_pkg::GEN_L7) ? l : lfsr_g_r;
    unique case (gmode_r)
      sptc_pkg::GEN_L15, sptc_pkg::GEN_L7: tx_nxt = w;
      sptc_pkg::GEN_FIX: tx_nxt = pat_r;
      sptc_pkg::GEN_BAL: tx_nxt = seq_r[0] ? ~pat_r : pat_r;
      sptc_pkg::GEN_SEQ: begin
        unique case (seq_r)
          2'h0: tx_nxt = '0;
          2'h1: tx_nxt = pat_r;
          2'h2: tx_nxt = {W{1'b1}};
          default: tx_nxt = ~pat_r;
        endcase
      end
      default: tx_nxt = '0;
    endcase
    if (inj_r && gmode_r != 3'h0) tx_nxt[0] = ~tx_nxt[0];
  end

  // counters with two-read pipeline: first read snapshots, second clears
  always_comb begin
    mcnt_nxt = mcnt_r;
    mpre_nxt = mpre_r;
    pcnt_nxt = pcnt_r;
    ppre_nxt = ppre_r;
    mhold_nxt = mhold_r;
    phold_nxt = phold_r;
    mrd_nxt = mrd_r;
    prd_nxt = prd_r;
    if (merr) begin
      mcnt_nxt = cnt_step(mcnt_r, mpre_r);
      if (mcnt_r[15]) mpre_nxt = mpre_r + 7'h01;
    end
    if (perr_ev) begin
      pcnt_nxt = cnt_step(pcnt_r, ppre_r);
      if (pcnt_r[15]) ppre_nxt = ppre_r + 7'h01;
    end
    // a clear on the second read beats a same-cycle error; the snapshot has it
    if (rd_hit(RD, ADDR, `SPTC_OFF_MATCH)) begin
      mhold_nxt = mcnt_nxt;
      mrd_nxt = ~mrd_r;
      if (mrd_r) begin
        mcnt_nxt = 16'h0000;
        mpre_nxt = 7'h00;
      end
    end
    if (rd_hit(RD, ADDR, `SPTC_OFF_PHASE)) begin
      phold_nxt = pcnt_nxt;
      prd_nxt = ~prd_r;
      if (prd_r) begin
        pcnt_nxt = 16'h0000;
        ppre_nxt = 7'h00;
      end
    end
  end

  // loss-of-signal filter counts prescaler ticks only
  always_comb begin
    los_cnt_nxt = los_cnt_r;
    los_nxt = los_r;
    if (rxovr_r[`SPTC_LOSF_HI:`SPTC_LOSF_LO] == 2'b11) begin
      if (SIGNAL_PRESENT) begin
        los_cnt_nxt = 8'h00;
        los_nxt = 1'b0;
      end else if (PRESCALE_EN) begin
        if (los_cnt_r >= `SPTC_LOS_FILT_CYC - 8'd1) los_nxt = 1'b1;
        else los_cnt_nxt = los_cnt_r + 8'h01;
      end
    end else begin
      // reserved codes 01/10 behave as filtering off
      los_cnt_nxt = 8'h00;
      los_nxt = !SIGNAL_PRESENT;
    end
    rxe_nxt = rxovr_r[`SPTC_OVR_EN_BIT] ? rxovr_r[13:0] : RX_STATUS;
  end

  // interrupts: 0 matcher error, 1 phase error, 2 counter overflow
  always_comb begin
    ovf_ev = (mcnt_nxt == 16'hFFFF && mcnt_r != 16'hFFFF) ||
             (pcnt_nxt == 16'hFFFF && pcnt_r != 16'hFFFF);
    ist_nxt = ist_r;
    if (WR && ADDR == `SPTC_OFF_IRQ_STAT) ist_nxt = ist_r & ~WDATA[2:0];
    ist_nxt = ist_nxt | {ovf_ev, perr_ev, merr};                       // set beats clear
    irq_nxt = |(ist_nxt & imsk_nxt);
    rd_nxt = 32'h0;
    if (RD) begin
      unique case (ADDR)
        `SPTC_OFF_RXOVR:  rd_nxt = rxovr_r;
        `SPTC_OFF_PATGEN: rd_nxt = {2'b00, pat_r, inj_r, gmode_r, 16'h0000};
        `SPTC_OFF_MATCH:  rd_nxt = {mhold_r, 12'h000, sync_r, mmode_r};
        `SPTC_OFF_PHASE:  rd_nxt = {4'h0, PHASE_SELECTOR_VALUE,
                                    PHASE_FRACTION_BITS, phold_r};
        `SPTC_OFF_IRQ_STAT: rd_nxt = {29'h0, ist_r};
        `SPTC_OFF_IRQ_MASK: rd_nxt = {29'h0, imsk_r};
        default: rd_nxt = 32'h0;
      endcase
    end
  end

  // software-visible control fields
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxovr_r  <= `SPTC_RXOVR_RST;
      gmode_r  <= 3'h0;
      inj_r    <= 1'b0;
      pat_r    <= '0;
      mmode_r  <= 3'h0;
      sync_r   <= 1'b0;
      imsk_r   <= 3'h0;
    end else begin
      rxovr_r  <= rxovr_nxt;
      gmode_r  <= gmode_nxt;
      inj_r    <= inj_nxt;
      pat_r    <= pat_nxt;
      mmode_r  <= mmode_nxt;
      sync_r   <= sync_nxt;
      imsk_r   <= imsk_nxt;
    end
  end

  // checker sync state, checker lfsr and bit history
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sst_r    <= sptc_pkg::SYN_IDLE;
      lfsr_c_r <= 15'h0000;
      hist_r   <= 10'h000;
    end else begin
      sst_r    <= sst_nxt;
      lfsr_c_r <= lfsr_c_nxt;
      hist_r   <= hist_nxt;
    end
  end

  // generator; the all-ones seed keeps the lfsr out of its stuck state
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lfsr_g_r <= 15'h7FFF;
      seq_r    <= 2'h0;
      tx_r     <= '0;
    end else begin
      lfsr_g_r <= lfsr_g_nxt;
      seq_r    <= seq_nxt;
      tx_r     <= tx_nxt;
    end
  end

  // both error counters with their read pipelines
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mcnt_r   <= 16'h0000;
      pcnt_r   <= 16'h0000;
      mpre_r   <= 7'h00;
      ppre_r   <= 7'h00;
      mhold_r  <= 16'h0000;
      phold_r  <= 16'h0000;
      mrd_r    <= 1'b0;
      prd_r    <= 1'b0;
    end else begin
      mcnt_r   <= mcnt_nxt;
      pcnt_r   <= pcnt_nxt;
      mpre_r   <= mpre_nxt;
      ppre_r   <= ppre_nxt;
      mhold_r  <= mhold_nxt;
      phold_r  <= phold_nxt;
      mrd_r    <= mrd_nxt;
      prd_r    <= prd_nxt;
    end
  end

  // loss filter and effective receive controls
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      los_cnt_r <= 8'h00;
      los_r    <= 1'b0;
      rxe_r    <= 14'h0000;
    end else begin
      los_cnt_r <= los_cnt_nxt;
      los_r    <= los_nxt;
      rxe_r    <= rxe_nxt;
    end
  end

  // interrupt status, interrupt line and read data
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ist_r    <= 3'h0;
      irq_r    <= 1'b0;
      rd_r     <= 32'h0000_0000;
    end else begin
      ist_r    <= ist_nxt;
      irq_r    <= irq_nxt;
      rd_r     <= rd_nxt;
    end
  end

  assign RDATA        = rd_r;
  assign IRQ          = irq_r;
  assign RX_EFFECTIVE = rxe_r;
  assign SIGNAL_LOSS  = los_r;
  assign TX_WORD      = tx_r;
endmodule : sptc_ctl
`default_nettype wire

//--- sptc_props.sv
// concurrent checks on the lane pattern test block ports
`timescale 1ns/1ps
`default_nettype none
`include "sptc_params.svh"
module sptc_props (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [13:0] RX_STATUS,
  input wire logic        SIGNAL_PRESENT,
  input wire logic [13:0] RX_EFFECTIVE,
  input wire logic        SIGNAL_LOSS
);
  logic ovr_r;
  logic ovr_nxt;
  // shadow of the override enable, to know when status should pass through
  always_comb ovr_nxt = (WR && ADDR == `SPTC_OFF_RXOVR) ? WDATA[14] : ovr_r;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) ovr_r <= 1'b0;
    else ovr_r <= ovr_nxt;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_ovr_rsv; $past(RD) && $past(ADDR) == `SPTC_OFF_RXOVR |-> RDATA[31:15] == 17'h0;
  endproperty
  a_ovr_rsv: assert property (p_ovr_rsv) else $error("override upper bits set");
  property p_mat_rsv; $past(RD) && $past(ADDR) == `SPTC_OFF_MATCH |-> RDATA[15:4] == 12'h0;
  endproperty
  a_mat_rsv: assert property (p_mat_rsv) else $error("matcher reserved bits set");
  property p_mat_scale; $past(RD) && $past(ADDR) == `SPTC_OFF_MATCH
    |-> !RDATA[31] || RDATA[30:16] >= 15'h0100; endproperty
  a_mat_scale: assert property (p_mat_scale) else $error("scaled count too low");
  property p_ph_rsv; $past(RD) && $past(ADDR) == `SPTC_OFF_PHASE |-> RDATA[31:28] == 4'h0;
  endproperty
  a_ph_rsv: assert property (p_ph_rsv) else $error("phase reserved bits set");
  property p_ph_scale; $past(RD) && $past(ADDR) == `SPTC_OFF_PHASE
    |-> !RDATA[15] || RDATA[14:0] >= 15'h0100; endproperty
  a_ph_scale: assert property (p_ph_scale) else $error("phase count too low");
  property p_pass; $past(RST_N) && !$past(ovr_r) |-> RX_EFFECTIVE == $past(RX_STATUS);
  endproperty
  a_pass: assert property (p_pass) else $error("status not passed through");
  property p_los_rise; $rose(SIGNAL_LOSS) |-> !$past(SIGNAL_PRESENT); endproperty
  a_los_rise: assert property (p_los_rise) else $error("loss with signal present");
endmodule : sptc_props
`default_nettype wire

//--- sptc_peer.sv
// far-side model: serial loopback or own lfsr stream, prescaler, signal detect
`timescale 1ns/1ps
`default_nettype none
module sptc_peer (
  input  wire logic       clk,
  input  wire logic [9:0] tx_word,
  input  wire logic [1:0] pmode,
  input  wire logic       flip,
  input  wire logic       sig,
  output logic            rx_bit,
  output logic            rx_valid,
  output logic            tick,
  output logic            present
);
  logic [3:0]  cnt = 4'h0;
  logic [9:0]  wsr = 10'h000;
  logic [14:0] hist = 15'h0001;
  logic        nb;
  // one word per 11 cycles, lsb first; a serial line cannot take a word per clock
  always_comb nb = pmode == 2'h1 ? hist[14] ^ hist[13] :
                   pmode == 2'h2 ? hist[6] ^ hist[5] : wsr[0];
  always_ff @(posedge clk) begin
    cnt <= cnt == 4'hA ? 4'h0 : cnt + 4'h1;
    wsr <= cnt == 4'hA ? tx_word : {1'b0, wsr[9:1]};
    if (cnt != 4'hA) hist <= {hist[13:0], nb};
  end
  assign rx_valid = cnt != 4'hA;
  assign rx_bit = nb ^ flip;
  assign tick = cnt[1:0] == 2'h3;
  assign present = sig;
endmodule : sptc_peer
`default_nettype wire

//--- test_serdes_pattern_test_ctl.sv
// self-checking bench for the lane pattern test block
`timescale 1ns/1ps
`default_nettype none
`include "sptc_params.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module test_serdes_pattern_test_ctl;
  typedef struct packed { logic w; logic [11:0] a; logic [31:0] d; } sptc_row_t;
  localparam logic [9:0] PAT = 10'h2C5;
  logic        clk = 1'b0, rst_n = 1'b0, wrs = 1'b0, rds = 1'b0;
  logic        flip = 1'b0, sig = 1'b1, perr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [1:0]  pmode = 2'h0;
  logic [9:0]  tx_word, ex;
  logic [13:0] rx_eff;
  logic        irq, loss, rxb, rxv, tick, pres;
  int          fails = 0, compares = 0, n, i, m;
  sptc_row_t   rows [6] = '{
    '{1'b0, `SPTC_OFF_RXOVR, 32'h0000_101E},
    '{1'b0, `SPTC_OFF_PATGEN, 32'h0},
    '{1'b1, `SPTC_OFF_RXOVR, 32'hFFFF_FFFF},
    '{1'b0, `SPTC_OFF_RXOVR, 32'h0000_7FFF},
    '{1'b1, `SPTC_OFF_RXOVR, 32'h0000_101E},
    '{1'b0, 12'h004, 32'h0}};
  sptc_ctl #(.W(10)) u_dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wrs), .RD(rds), .RDATA(rdata), .IRQ(irq), .RX_STATUS(14'h0A5A), .PRESCALE_EN(tick),
    .SIGNAL_PRESENT(pres), .RX_BIT(rxb), .RX_BIT_VALID(rxv), .PHASE_SELECTOR_VALUE(11'h4B3),
    .PHASE_FRACTION_BITS(1'b1), .PHASE_ERR(perr), .RX_EFFECTIVE(rx_eff),
    .SIGNAL_LOSS(loss), .TX_WORD(tx_word));
  sptc_peer u_peer (.clk(clk), .tx_word(tx_word), .pmode(pmode), .flip(flip), .sig(sig),
    .rx_bit(rxb), .rx_valid(rxv), .tick(tick), .present(pres));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wrs <= 1'b1;
    @(posedge clk);
    wrs <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rds <= 1'b1;
    @(posedge clk);
    rds <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    forever #20 clk = ~clk;
  end
  // whole run is some 1500 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      else begin
        rd(rows[k].a, q);
        `CHK("reg", rows[k].d, q)
      end
    end
    `CHK("rx_eff", 14'h0A5A, rx_eff)
    wr(`SPTC_OFF_RXOVR, 32'h0000_40E9);
    repeat (2) @(posedge clk);
    #1 `CHK("rx_eff", 14'h00E9, rx_eff)
    wr(`SPTC_OFF_RXOVR, 32'h0000_701E);
    sig <= 1'b0;
    n = 0;
    #1;
    for (i = 0; i < 1000 && loss !== 1'b1; i++) begin
      n += int'(tick);
      @(posedge clk);
      #1;
    end
    `CHK("ticks", 128, n)
    for (m = 3; m <= 5; m++) begin
      wr(`SPTC_OFF_PATGEN, {2'h0, PAT, 1'b0, m[2:0], 16'h0});
      repeat (3) @(posedge clk);
      #1;
      // look off the edge, or the word being launched is missed
      for (n = 0; n < 8 && tx_word !== PAT; n++) begin
        @(posedge clk);
        #1;
      end
      for (i = 0; i < 4; i++) begin
        ex = m == 3 ? PAT : m == 4 ? (i[0] ? ~PAT : PAT) :
             i == 0 ? PAT : i == 1 ? 10'h3FF : i == 2 ? ~PAT : 10'h000;
        `CHK("tx_word", ex, tx_word)
        @(posedge clk);
        #1;
      end
    end
    wr(`SPTC_OFF_PATGEN, {2'h0, PAT, 1'b1, 3'h3, 16'h0});
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 n += int'(tx_word === (PAT ^ 10'h001));
    end
    `CHK("inject", 1, n)
    sig <= 1'b1;
    rd(`SPTC_OFF_PATGEN, q);
    `CHK("patgen", {2'h0, PAT, 1'b0, 3'h3, 16'h0}, q)
    `CHK("loss", 1'b0, loss)
    for (m = 1; m <= 4; m++) begin
      pmode <= m < 3 ? m[1:0] : 2'h0;
      wr(`SPTC_OFF_PATGEN, {2'h0, PAT, 1'b0, m[2:0], 16'h0});
      wr(`SPTC_OFF_MATCH, {28'h0, 1'b1, m[2:0]});
      repeat (40) @(posedge clk);
      wr(`SPTC_OFF_MATCH, {29'h0, m[2:0]});
      repeat (2) rd(`SPTC_OFF_MATCH, q);
      repeat (100) @(posedge clk);
      repeat (2) rd(`SPTC_OFF_MATCH, q);
      `CHK("match", {29'h0, m[2:0]}, q)
      if (m > 2) begin
        @(posedge clk iff u_peer.cnt == 4'h0);
        flip <= 1'b1;
        @(posedge clk);
        flip <= 1'b0;
        repeat (40) @(posedge clk);
        repeat (2) rd(`SPTC_OFF_MATCH, q);
        `CHK("errors", 16'h0002, q[31:16])
      end
    end
    wr(`SPTC_OFF_IRQ_STAT, 32'h7);
    repeat (3) begin
      @(posedge clk);
      perr <= 1'b1;
      @(posedge clk);
      perr <= 1'b0;
    end
    repeat (2) rd(`SPTC_OFF_PHASE, q);
    `CHK("phase", {4'h0, 11'h4B3, 1'b1, 16'h0003}, q)
    `CHK("irq", 1'b0, irq)
    wr(`SPTC_OFF_IRQ_MASK, 32'h2);
    @(posedge clk);
    #1 `CHK("irq", 1'b1, irq)
    wr(`SPTC_OFF_IRQ_STAT, 32'h2);
    @(posedge clk);
    #1 `CHK("irq", 1'b0, irq)
    rst_n <= 1'b0;
    @(posedge clk);
    #1 `CHK("tx_word", 10'h000, tx_word)
    rst_n <= 1'b1;
    rd(`SPTC_OFF_PATGEN, q);
    `CHK("patgen", 32'h0, q)
    finish_test();
  end
endmodule : test_serdes_pattern_test_ctl
bind sptc_ctl sptc_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .RX_STATUS(RX_STATUS), .SIGNAL_PRESENT(SIGNAL_PRESENT),
  .RX_EFFECTIVE(RX_EFFECTIVE), .SIGNAL_LOSS(SIGNAL_LOSS));
`default_nettype wire
